// *** src/smpr_pkg.sv ***
/*
  Shared constants and carrier types of the motion-parameter register set.
  Assumes one 100 MHz clock and a command decoder that presents one access per strobe.
*/
package smpr_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [4:0] SMPR_ADDR_ELPOS  = 5'h02;
  localparam logic [4:0] SMPR_ADDR_MARK   = 5'h03;
  localparam logic [4:0] SMPR_ADDR_SPEED  = 5'h04;
  localparam logic [4:0] SMPR_ADDR_RAMPUP = 5'h05;
  localparam logic [4:0] SMPR_ADDR_RAMPDN = 5'h06;
  localparam logic [4:0] SMPR_ADDR_MAX    = 5'h07;
  localparam logic [4:0] SMPR_ADDR_MIN    = 5'h08;
  localparam logic [4:0] SMPR_ADDR_KHOLD  = 5'h09;
  localparam logic [4:0] SMPR_ADDR_FSSPD  = 5'h15;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          SMPR_LOWOPT_BIT  = 12;
  localparam int          SMPR_BOOST_BIT   = 10;
  localparam logic [8:0]  SMPR_RST_ELPOS   = 9'h000;
  localparam logic [21:0] SMPR_RST_MARK    = 22'h000000;
  localparam logic [11:0] SMPR_RST_RAMPUP  = 12'h08a;
  localparam logic [11:0] SMPR_RST_RAMPDN  = 12'h08a;
  localparam logic [11:0] SMPR_RAMPUP_RSVD = 12'hfff;
  localparam logic [9:0]  SMPR_RST_MAX     = 10'h041;
  localparam logic [12:0] SMPR_RST_MIN     = 13'h0000;
  localparam logic [10:0] SMPR_RST_FSSPD   = 11'h027;
  localparam logic [7:0]  SMPR_RST_KVAL    = 8'h29;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         SMPR_CLK_NS   = 10;
  localparam int         SMPR_TICK_NS  = 250;
  localparam logic [4:0] SMPR_TICK_CYC = 5'((SMPR_TICK_NS + SMPR_CLK_NS - 1) / SMPR_CLK_NS);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    SMPR_STOPPED = 4'h1,
    SMPR_ACCEL   = 4'h2,
    SMPR_CONST   = 4'h4,
    SMPR_DECEL   = 4'h8
  } smpr_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [21:0] data;
  } smpr_cmd_t;

  typedef struct packed {
    logic [11:0] rampUp;
    logic [11:0] rampDown;
    logic [9:0]  rateCeiling;
    logic [11:0] rateFloor;
  } smpr_profile_t;

endpackage

// *** src/smpr_fullstep_cmp.sv ***
/*
  Full-step switch-over comparator.
  Assumes the speed input is already clamped and held in a register.
*/
`timescale 1ns/1ps
`default_nettype none
module smpr_fullstep_cmp (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [19:0] speed,
  input  wire logic [9:0]  fsField,
  output logic             fullStep
);
  import smpr_pkg::*;

  // Threshold is (field + 0.5) * 2^-18; in 0.28 units that is {field, 1, 9 zeros},
  // so a zero field still means about 7.63 step/s and never forces full step.
  logic [19:0] threshold;
  assign threshold = {fsField, 1'b1, 9'h000};

  always_ff @(posedge clk) begin
    if (reset) begin
      fullStep <= 1'b0;
    end else begin
      fullStep <= (speed > threshold);
    end
  end

  chk_fullstep_switch: assert property (
    @(posedge clk) disable iff (reset)
    (speed > {fsField, 1'b1, 9'h000}) |=> fullStep)
    else $error("full step not entered above threshold");

  chk_zero_threshold: assert property (
    @(posedge clk) disable iff (reset)
    (fsField == 10'h000 && speed <= 20'h00200) |=> !fullStep)
    else $error("zero threshold forced full step");

endmodule
`default_nettype wire

// *** src/smpr_amp_select.sv ***
/*
  Drive amplitude selector fed to the PWM modulators.
  Assumes the profile state comes one-hot from the motion engine.
*/
`timescale 1ns/1ps
`default_nettype none
module smpr_amp_select (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire smpr_pkg::smpr_state_t state,
  input  wire logic [7:0]           holdAmp,
  input  wire logic [7:0]           runAmp,
  input  wire logic [7:0]           accelAmp,
  input  wire logic [7:0]           decelAmp,
  output logic [7:0]                amplitude
);
  import smpr_pkg::*;

  // Code n means n/256 of supply; compensations are applied downstream.
  always_ff @(posedge clk) begin
    if (reset) begin
      amplitude <= SMPR_RST_KVAL;
    end else begin
      unique case (state)
        SMPR_STOPPED: amplitude <= holdAmp;
        SMPR_CONST:   amplitude <= runAmp;
        SMPR_ACCEL:   amplitude <= accelAmp;
        SMPR_DECEL:   amplitude <= decelAmp;
        default:      amplitude <= holdAmp;
      endcase
    end
  end

  chk_amp_hold: assert property (
    @(posedge clk) disable iff (reset)
    state == SMPR_STOPPED |=> amplitude == $past(holdAmp))
    else $error("hold amplitude not applied when stopped");

  chk_amp_run: assert property (
    @(posedge clk) disable iff (reset)
    state == SMPR_CONST |=> amplitude == $past(runAmp))
    else $error("run amplitude not applied at constant speed");

endmodule
`default_nettype wire

// *** src/smpr_motion_regs.sv ***
/*
  Motion-parameter register set of the stepper motion engine: electrical
  position, bookmark, present rate, ramp rates, rate limits, full-step
  threshold and the four drive amplitudes.
  Assumes a command decoder that issues one register access per strobe and
  a profile generator that supplies running state, speed and step pulses.
*/
// Notes on behaviour
// - Electrical position is 9 bits: two step bits, seven 1/128 microstep bits.
// - A host write to electrical position takes effect at once if the motor is stopped.
// - Writes to position, ramps or floor while running raise command error.
// - Present rate is read-only; writes are dropped and raise command error.
// - Bookmark holds 22-bit two's complement position in selected step units.
// - Present rate reads as unsigned 0.28 steps per 250 ns tick.
// - Ramp-up rate is unsigned 0.40; host never writes all ones.
// - Ramp-down rate is unsigned 0.40 steps per tick squared.
// - Rate ceiling is unsigned 0.18 steps per tick.
// - Present rate exceeds the programmed rate ceiling for at most one cycle after the ceiling is lowered.
// - Rate floor is 13 bits: bit 12 optimisation enable, 11..0 speed.
// - With optimisation on, floor is a threshold and profile floor is zero.
// - Above threshold (field + 0.5) * 2^-18 switch to full stepping.
// - Maximum threshold code keeps microstepping unless speed exceeds it.
// - Zero threshold means about 7.63 step/s, not forced full step.
// - Threshold register is 11 bits; bit 10 selects full-step boost.
// - Stopped motor uses hold amplitude.
// - Constant speed uses run amplitude.
// - Acceleration and deceleration start from their own amplitudes.
// - Amplitude code n drives n/256 of supply voltage.
// - A 3-bit selector picks full step down to 1/128 microstep.
`timescale 1ns/1ps
`default_nettype none
module smpr_motion_regs (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire smpr_pkg::smpr_cmd_t   cmd,
  input  wire logic                  motorRunning,
  input  wire smpr_pkg::smpr_state_t profileState,
  input  wire logic [2:0]            stepSel,
  input  wire logic                  stepPulse,
  input  wire logic                  stepDir,
  input  wire logic [19:0]           engineSpeed,
  output logic [21:0]                rdData,
  output logic                       rdValid,
  output logic                       cmdError,
  output logic [8:0]                 elPos,
  output logic [21:0]                bookmark,
  output smpr_pkg::smpr_profile_t    profileCfg,
  output logic                       lowRateOptEn,
  output logic [11:0]                lowRateThreshold,
  output logic [19:0]                presentRate,
  output logic                       fullStepActive,
  output logic                       boostMode,
  output logic [7:0]                 driveAmplitude,
  output logic                       tickStrobe
);
  import smpr_pkg::*;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic isWrite(input smpr_cmd_t c, input logic [4:0] a);
    isWrite = c.wr && (c.addr == a);
  endfunction

  // One step of the selected resolution, in 1/128 units.
  function automatic logic [8:0] stepInc(input logic [2:0] sel);
    stepInc = 9'h001 << (3'h7 - sel);
  endfunction

  // Keeps only the position bits that the selected resolution can reach.
  function automatic logic [8:0] resMask(input logic [2:0] sel);
    resMask = 9'h1ff << (3'h7 - sel);
  endfunction

  logic [12:0] floorReg_ff;
  logic [10:0] fsReg_ff;
  logic [7:0]  kval_ff [4];
  logic [2:0]  prevSel_ff;
  logic [4:0]  tickCnt_ff;
  logic        selChanged;
  logic [8:0]  nxt_stepPos;
  logic        guardedWr;

  assign selChanged = (stepSel != prevSel_ff);
  assign nxt_stepPos = stepDir ? 9'(elPos + stepInc(stepSel))
                               : 9'(elPos - stepInc(stepSel));

  // ----------------------------------------
  // Write protection
  // ----------------------------------------
  // These writes are only legal while the motor stands still.
  assign guardedWr = isWrite(cmd, SMPR_ADDR_ELPOS) || isWrite(cmd, SMPR_ADDR_RAMPUP) ||
                     isWrite(cmd, SMPR_ADDR_RAMPDN) || isWrite(cmd, SMPR_ADDR_MIN);

  always_ff @(posedge clk) begin
    if (reset) begin
      cmdError <= 1'b0;
    end else begin
      cmdError <= isWrite(cmd, SMPR_ADDR_SPEED)
                  || (guardedWr && motorRunning);
    end
  end

  // ----------------------------------------
  // Electrical position
  // ----------------------------------------
  // Priority: host write, then resolution change, then engine step.
  // The host is trusted to mask its write; the engine's own steps are masked.
  always_ff @(posedge clk) begin
    if (reset) begin
      elPos <= SMPR_RST_ELPOS;
    end else if (isWrite(cmd, SMPR_ADDR_ELPOS) && !motorRunning) begin
      elPos <= cmd.data[8:0];
    end else if (selChanged) begin
      elPos <= {elPos[8:7], 7'h00};
    end else if (stepPulse) begin
      elPos <= nxt_stepPos & resMask(stepSel);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prevSel_ff <= 3'h7;
    end else begin
      prevSel_ff <= stepSel;
    end
  end

  // ----------------------------------------
  // Bookmark
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      bookmark <= SMPR_RST_MARK;
    end else if (isWrite(cmd, SMPR_ADDR_MARK)) begin
      bookmark <= cmd.data;
    end
  end

  // ----------------------------------------
  // Ramp rates and rate limits
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      profileCfg.rampUp      <= SMPR_RST_RAMPUP;
      profileCfg.rampDown    <= SMPR_RST_RAMPDN;
      profileCfg.rateCeiling <= SMPR_RST_MAX;
      profileCfg.rateFloor   <= 12'h000;
    end else begin
      // The whole profile word has one driver; the floor follows its register a cycle later.
      profileCfg.rateFloor <= floorReg_ff[SMPR_LOWOPT_BIT] ? 12'h000
                                                           : floorReg_ff[11:0];
      if (isWrite(cmd, SMPR_ADDR_RAMPUP) && !motorRunning) begin
        profileCfg.rampUp <= cmd.data[11:0];
      end
      if (isWrite(cmd, SMPR_ADDR_RAMPDN) && !motorRunning) begin
        profileCfg.rampDown <= cmd.data[11:0];
      end
      if (isWrite(cmd, SMPR_ADDR_MAX)) begin
        profileCfg.rateCeiling <= cmd.data[9:0];
      end
    end
  end

  // The floor write still lands while running; only the error is raised.
  always_ff @(posedge clk) begin
    if (reset) begin
      floorReg_ff <= SMPR_RST_MIN;
    end else if (isWrite(cmd, SMPR_ADDR_MIN)) begin
      floorReg_ff <= cmd.data[12:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lowRateOptEn     <= 1'b0;
      lowRateThreshold <= 12'h000;
    end else begin
      lowRateOptEn     <= floorReg_ff[SMPR_LOWOPT_BIT];
      lowRateThreshold <= floorReg_ff[11:0];
    end
  end

  // ----------------------------------------
  // Present rate
  // ----------------------------------------
  // The engine should already respect the ceiling; clamping here keeps a
  // late ceiling write from showing a rate above it for more than one cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      presentRate <= 20'h00000;
    end else if (engineSpeed > {profileCfg.rateCeiling, 10'h000}) begin
      presentRate <= {profileCfg.rateCeiling, 10'h000};
    end else begin
      presentRate <= engineSpeed;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tickCnt_ff <= 5'h00;
      tickStrobe <= 1'b0;
    end else begin
      tickStrobe <= (tickCnt_ff == SMPR_TICK_CYC - 5'h01);
      tickCnt_ff <= (tickCnt_ff == SMPR_TICK_CYC - 5'h01) ? 5'h00 : 5'(tickCnt_ff + 5'h01);
    end
  end

  // ----------------------------------------
  // Full-step threshold and amplitudes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      fsReg_ff  <= SMPR_RST_FSSPD;
      boostMode <= 1'b0;
    end else begin
      if (isWrite(cmd, SMPR_ADDR_FSSPD)) begin
        fsReg_ff <= cmd.data[10:0];
      end
      boostMode <= fsReg_ff[SMPR_BOOST_BIT];
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_kval
    always_ff @(posedge clk) begin
      if (reset) begin
        kval_ff[i] <= SMPR_RST_KVAL;
      end else if (isWrite(cmd, 5'(SMPR_ADDR_KHOLD + 5'(i)))) begin
        kval_ff[i] <= cmd.data[7:0];
      end
    end
  end

  smpr_fullstep_cmp u_fullstep (
    .clk      (clk),
    .reset    (reset),
    .speed    (presentRate),
    .fsField  (fsReg_ff[9:0]),
    .fullStep (fullStepActive)
  );

  smpr_amp_select u_amp (
    .clk       (clk),
    .reset     (reset),
    .state     (profileState),
    .holdAmp   (kval_ff[0]),
    .runAmp    (kval_ff[1]),
    .accelAmp  (kval_ff[2]),
    .decelAmp  (kval_ff[3]),
    .amplitude (driveAmplitude)
  );

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rdValid <= 1'b0;
      rdData  <= 22'h000000;
    end else begin
      rdValid <= cmd.rd;
      if (cmd.rd) begin
        case (cmd.addr)
          SMPR_ADDR_ELPOS:  rdData <= {13'h0000, elPos};
          SMPR_ADDR_MARK:   rdData <= bookmark;
          SMPR_ADDR_SPEED:  rdData <= {2'h0, presentRate};
          SMPR_ADDR_RAMPUP: rdData <= {10'h000, profileCfg.rampUp};
          SMPR_ADDR_RAMPDN: rdData <= {10'h000, profileCfg.rampDown};
          SMPR_ADDR_MAX:    rdData <= {12'h000, profileCfg.rateCeiling};
          SMPR_ADDR_MIN:    rdData <= {9'h000, floorReg_ff};
          SMPR_ADDR_FSSPD:  rdData <= {11'h000, fsReg_ff};
          5'h09:            rdData <= {14'h0000, kval_ff[0]};
          5'h0a:            rdData <= {14'h0000, kval_ff[1]};
          5'h0b:            rdData <= {14'h0000, kval_ff[2]};
          5'h0c:            rdData <= {14'h0000, kval_ff[3]};
          default:          rdData <= 22'h000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_plainStep;
    stepPulse && !selChanged && !isWrite(cmd, SMPR_ADDR_ELPOS);
  endsequence

  chk_elpos_write: assert property (
    isWrite(cmd, SMPR_ADDR_ELPOS) && !motorRunning |=> elPos == $past(cmd.data[8:0]))
    else $error("electrical position write not applied");

  chk_elpos_step: assert property (
    s_plainStep |=> elPos == ($past(nxt_stepPos) & resMask($past(stepSel))))
    else $error("electrical position step wrong");

  chk_ramp_guard: assert property (
    isWrite(cmd, SMPR_ADDR_RAMPUP) && motorRunning
    |=> cmdError && $stable(profileCfg.rampUp))
    else $error("running ramp write not refused");

  chk_floor_running: assert property (
    isWrite(cmd, SMPR_ADDR_MIN) && motorRunning
    |=> cmdError && floorReg_ff == $past(cmd.data[12:0]))
    else $error("running floor write handled wrongly");

  chk_speed_readonly: assert property (
    isWrite(cmd, SMPR_ADDR_SPEED) |=> cmdError ##1 !cmdError || $past(cmd.wr))
    else $error("present rate write not flagged");

  chk_rate_clamp: assert property (
    presentRate <= {$past(profileCfg.rateCeiling), 10'h000})
    else $error("present rate above ceiling");

  chk_floor_zero: assert property (
    $past(floorReg_ff[SMPR_LOWOPT_BIT]) |-> profileCfg.rateFloor == 12'h000 && lowRateOptEn)
    else $error("profile floor not zero with optimisation on");

  chk_tick_period: assert property (
    tickStrobe |=> !tickStrobe [*5] ##20 tickStrobe)
    else $error("tick strobe period wrong");

  chk_elpos_refuse: assert property (
    isWrite(cmd, SMPR_ADDR_ELPOS) && motorRunning && !stepPulse && !selChanged
    |=> cmdError && $stable(elPos))
    else $error("running position write not refused");

  chk_mark_write: assert property (
    isWrite(cmd, SMPR_ADDR_MARK) |=> bookmark == $past(cmd.data))
    else $error("bookmark write not applied");

  chk_floor_plain: assert property (
    !$past(floorReg_ff[SMPR_LOWOPT_BIT]) |-> profileCfg.rateFloor == $past(floorReg_ff[11:0]))
    else $error("profile floor does not follow the floor field");

  chk_rate_follow: assert property (
    $past(engineSpeed) <= {$past(profileCfg.rateCeiling), 10'h000} |-> presentRate == $past(engineSpeed))
    else $error("present rate does not follow engine speed");

  chk_read_ramp: assert property (
    cmd.rd && cmd.addr == SMPR_ADDR_RAMPDN |=> rdValid && rdData == {10'h000, $past(profileCfg.rampDown)})
    else $error("ramp-down read-back wrong");

endmodule
`default_nettype wire

// *** test/smpr_host_model.sv ***
/*
  Host model that issues register reads and writes to the motion-parameter set.
  Assumes the bench calls its task and that cmd is sampled on rising clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module smpr_host_model (
  input  wire logic          clk,
  output var  smpr_pkg::smpr_cmd_t cmd
);
  import smpr_pkg::*;

  initial cmd = '0;

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  // The strobe drops one cycle after it rises, so back-to-back calls leave an idle cycle between accesses.
  task automatic access(input logic wr, input logic rd, input logic [4:0] addr, input logic [21:0] data,
                        input logic [2:0] sel, output logic [21:0] sent);
    sent = data;
    if (addr == SMPR_ADDR_RAMPUP && data[11:0] == SMPR_RAMPUP_RSVD) begin
      sent[11:0] = 12'hffe;
    end
    if (addr == SMPR_ADDR_ELPOS) begin
      sent[8:0] = data[8:0] & (9'h1ff << (3'h7 - sel));
    end
    @(negedge clk);
    cmd <= '{wr: wr, rd: rd, addr: addr, data: sent};
    @(negedge clk);
    cmd <= '0;
  endtask
endmodule
`default_nettype wire

// *** test/smpr_motion_regs_tb.sv ***
/*
  Self-checking bench of the motion-parameter register set.
  Assumes the design and host model files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module smpr_motion_regs_tb;
  import smpr_pkg::*;

  logic          clk = 1'b0;
  logic          reset = 1'b1;
  smpr_cmd_t     cmd;
  logic          motorRunning = 1'b0;
  smpr_state_t   profileState = SMPR_STOPPED;
  logic [2:0]    stepSel = 3'h7;
  logic          stepPulse = 1'b0;
  logic          stepDir = 1'b1;
  logic [19:0]   engineSpeed = 20'h0;
  logic [21:0]   rdData, bookmark, sent;
  logic          rdValid, cmdError, lowRateOptEn, fullStepActive, boostMode, tickStrobe;
  logic [8:0]    elPos, inc;
  smpr_profile_t profileCfg;
  logic [11:0]   lowRateThreshold;
  logic [19:0]   presentRate, thr, lim;
  logic [7:0]    driveAmplitude;
  logic [22:0]   expQ[$];
  logic [22:0]   note;
  logic [31:0]   rngState = 32'h27b81bf2;
  logic [31:0]   rnd;
  logic [21:0]   wrote[12];
  int            numErrors = 0;
  int            checkCount = 0;
  int            n;
  logic [4:0]    addrTab[12] = '{SMPR_ADDR_ELPOS, SMPR_ADDR_MARK, SMPR_ADDR_SPEED, SMPR_ADDR_RAMPUP,
    SMPR_ADDR_RAMPDN, SMPR_ADDR_MAX, SMPR_ADDR_MIN, SMPR_ADDR_KHOLD, 5'h0a, 5'h0b, 5'h0c, SMPR_ADDR_FSSPD};
  logic [21:0]   rstTab[12] = '{22'(SMPR_RST_ELPOS), SMPR_RST_MARK, 22'h0, 22'(SMPR_RST_RAMPUP),
    22'(SMPR_RST_RAMPDN), 22'(SMPR_RST_MAX), 22'(SMPR_RST_MIN), 22'(SMPR_RST_KVAL), 22'(SMPR_RST_KVAL),
    22'(SMPR_RST_KVAL), 22'(SMPR_RST_KVAL), 22'(SMPR_RST_FSSPD)};
  int            widTab[12] = '{9, 22, 20, 12, 12, 10, 13, 8, 8, 8, 8, 11};
  smpr_state_t   stTab[5] = '{SMPR_STOPPED, SMPR_ACCEL, SMPR_CONST, SMPR_DECEL, smpr_state_t'(4'h3)};
  int            ampIdx[5] = '{7, 9, 8, 10, 7};

  always #5 clk = ~clk;

  smpr_host_model host (.clk(clk), .cmd(cmd));

  smpr_motion_regs dut (.clk(clk), .reset(reset), .cmd(cmd), .motorRunning(motorRunning),
    .profileState(profileState), .stepSel(stepSel), .stepPulse(stepPulse), .stepDir(stepDir),
    .engineSpeed(engineSpeed), .rdData(rdData), .rdValid(rdValid), .cmdError(cmdError), .elPos(elPos),
    .bookmark(bookmark), .profileCfg(profileCfg), .lowRateOptEn(lowRateOptEn),
    .lowRateThreshold(lowRateThreshold), .presentRate(presentRate), .fullStepActive(fullStepActive),
    .boostMode(boostMode), .driveAmplitude(driveAmplitude), .tickStrobe(tickStrobe));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nextRand();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic regWrite(input int i, input logic [21:0] d, input logic err);
    if (err) expQ.push_back({1'b1, 22'h0});
    host.access(1'b1, 1'b0, addrTab[i], d, stepSel, sent);
    sent = sent & 22'((32'h1 << widTab[i]) - 32'h1);
  endtask

  task automatic regRead(input int i, input logic [21:0] e);
    logic [21:0] unused;
    expQ.push_back({1'b0, e});
    host.access(1'b0, 1'b1, addrTab[i], 22'h0, stepSel, unused);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Results are paired with notes in issue order; a result with no note pending is checked as an error flag, so only a read then mismatches.
  always @(negedge clk) begin
    if (!reset && (rdValid === 1'b1 || cmdError === 1'b1)) begin
      note = (expQ.size() > 0) ? expQ.pop_front() : 23'h7fffff;
      if (note[22]) begin
        check("error flag", {30'h0, cmdError, rdValid}, 32'h2);
      end else begin
        check("read data", {8'h0, cmdError, rdValid, rdData}, {8'h0, 2'b01, note[21:0]});
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 12; i++) regRead(i, rstTab[i]);
    regRead(0, 22'h0);
    expQ.push_back({1'b0, 22'h0});
    host.access(1'b0, 1'b1, 5'h1f, 22'h0, stepSel, sent);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      rnd = nextRand();
      regWrite(i, rnd[21:0], i == 2);
      wrote[i] = (i == 2) ? 22'h0 : sent;
      regRead(i, wrote[i]);
      if (i == 0) check("elPos", elPos, wrote[0]);
    end
    check("bookmark", bookmark, wrote[1]);
    check("rampUp", profileCfg.rampUp, wrote[3]);
    check("rampDown", profileCfg.rampDown, wrote[4]);
    check("rateCeiling", profileCfg.rateCeiling, wrote[5]);
    $display("test write readback done");
    motorRunning = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rnd = nextRand();
      regWrite(i, rnd[21:0], i != 1 && i != 5);
      if (i == 1 || i >= 5) wrote[i] = sent;
      regRead(i, wrote[i]);
    end
    motorRunning = 1'b0;
    $display("test running protection done");
    for (int b = 0; b < 2; b++) begin
      rnd = nextRand();
      regWrite(6, {9'h0, b[0], rnd[11:0]}, 1'b0);
      @(negedge clk);
      check("rateFloor", profileCfg.rateFloor, b ? 12'h0 : rnd[11:0]);
      check("lowRateOpt", {lowRateOptEn, lowRateThreshold}, {b[0], rnd[11:0]});
    end
    $display("test low rate option done");
    regWrite(5, 22'h3ff, 1'b0);
    for (int f = 0; f < 3; f++) begin
      rnd = nextRand();
      rnd[9:0] = (f == 0) ? 10'h0 : (f == 1) ? 10'h0ff : {1'b0, rnd[8:0]};
      regWrite(11, {11'h0, rnd[10:0]}, 1'b0);
      thr = {rnd[9:0], 1'b1, 9'h0};
      for (int s = 0; s < 2; s++) begin
        engineSpeed = thr + 20'(s);
        repeat (3) @(negedge clk);
        check("fullStep", fullStepActive, s);
        check("boost", boostMode, rnd[10]);
      end
    end
    for (int k = 0; k < 4; k++) begin
      rnd = nextRand();
      regWrite(5, {12'h0, rnd[9:0]}, 1'b0);
      lim = {rnd[9:0], 10'h0};
      rnd = nextRand();
      engineSpeed = rnd[19:0];
      repeat (2) @(negedge clk);
      check("presentRate", presentRate, (rnd[19:0] > lim) ? lim : rnd[19:0]);
      regRead(2, (rnd[19:0] > lim) ? lim : rnd[19:0]);
    end
    $display("test speed limits done");
    for (int k = 0; k < 5; k++) begin
      profileState = stTab[k];
      repeat (2) @(negedge clk);
      check("amplitude", driveAmplitude, wrote[ampIdx[k]]);
    end
    profileState = SMPR_STOPPED;
    $display("test amplitudes done");
    for (int s = 0; s < 8; s++) begin
      stepSel = 3'(s);
      repeat (2) @(negedge clk);
      check("microstep cleared", elPos[6:0], 7'h0);
      rnd = nextRand();
      regWrite(0, rnd[21:0], 1'b0);
      stepDir = rnd[31];
      stepPulse = 1'b1;
      @(negedge clk);
      stepPulse = 1'b0;
      @(negedge clk);
      inc = 9'h1 << (7 - s);
      check("elPos step", elPos, 9'(rnd[31] ? sent[8:0] + inc : sent[8:0] - inc));
    end
    $display("test step resolution done");
    n = 0;
    while (tickStrobe !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("tick seen", tickStrobe, 32'h1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tickStrobe !== 1'b1 && n < 40);
    check("tick period", n, SMPR_TICK_CYC);
    $display("test tick done");
    repeat (4) @(negedge clk);
    check("pending results", expQ.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire
